// ### rtseq_top.v
// Reset sequencer: sources, filters, start-up timers and cause flags with APB access.
//
// What this block does
// - Hold the core in reset while the power-on detector reports low supply.
// - Filter the external reset input so short glitches are ignored.
// - Watchdog reset acts only internally and never drives the reset pin.
// - Pin enable 0 means internal reset only; 1 means active-low pin reset.
// - Enable a weak pull-up on the pin while it serves as reset input.
// - Power-up timer gives 64 ms, triggered only by power-on or brown-out.
// - Keep the core in reset while the power-up timer runs.
// - Power-up timer disable bit: 1 disables the timer, 0 enables it.
// - Two-bit brown-out mode; value 10 disables detection during sleep only.
// - Brown-out reset when supply stays low longer than the minimum duration.
// - After a power-on or brown-out reset wait for supply above threshold, then the power-up timer.
// - A brown-out during the power-up timer restarts it from zero.
// - Crystal start-up timer starts after the power-up timer expires (after the supply wait if the timer is disabled), or on wake.
// - Crystal modes add 1024 oscillator periods after power-up, brown-out, wake.
// - Non-crystal modes add no crystal delay; no delay at all on wake.
// - Time-outs run regardless of the pin; late pin release starts at once.
// - Power-control register holds brown-out flag bit 0, power-on flag bit 1.
// - Brown-out flag writable to 1, cleared by brown-out reset.
// - Power-on flag cleared by power-on reset only; software writes 1.
// - Timeout and power-down flags are set per reset cause.
// - Status loads 0001 1xxx on power-up resets, uuu0 0uuu on watchdog wake from sleep, 000q quuu otherwise.
//
// Register access over APB was chosen for this implementation.
`include "rtseq_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module rtseq_top #(
  parameter [31:0] POWERUP_TIMER_CYCLES = `RTSEQ_POWERUP_TIMER_CYCLES,
  parameter [15:0] OSC_DIV     = 16'h0004
) (
  input  wire        clock,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        supply_ok_por,
  input  wire        supply_above_bor,
  input  wire        pin_level_in,
  output wire        pin_pullup_en,
  output wire        pin_out,
  output wire        pin_oe,
  input  wire        watchdog_reset,
  input  wire        watchdog_wake,
  input  wire        sleep_active,
  input  wire        ext_reset_pin_enable,
  input  wire        powerup_timer_disable,
  input  wire [1:0]  brownout_mode_field,
  output reg         core_reset
);

  ////////////////////////////////////////////////////////////////////////////
  localparam [2:0] ST_POR  = 3'h0;
  localparam [2:0] ST_BOR  = 3'h1;
  localparam [2:0] ST_POWERUP_TIMER = 3'h2;
  localparam [2:0] ST_OST  = 3'h3;
  localparam [2:0] ST_HOLD = 3'h4;
  localparam [2:0] ST_RUN  = 3'h5;
  localparam [2:0] ST_WAKE = 3'h6;

  reg  [1:0]  sync_por;
  reg  [1:0]  sync_bor;
  reg  [1:0]  sync_pin;
  reg  [1:0]  sync_wdr;
  reg  [1:0]  sync_wdw;
  reg  [3:0]  filt_cnt;
  reg         pin_low_filt;
  reg  [4:0]  bor_cnt;
  reg  [2:0]  state;
  reg  [31:0] powerup_timer_cnt;
  reg  [10:0] ost_cnt;
  reg  [15:0] osc_div_cnt;
  reg         por_flag;
  reg         bor_flag;
  reg         to_flag;
  reg         pd_flag;
  reg  [2:0]  status_upper;
  reg  [1:0]  clock_mode;
  reg         wdr_prev;
  reg         wdw_prev;
  reg         pin_prev;
  reg  [31:0] rdata;

  wire por_low     = ~sync_por[1];
  wire bor_enabled = (brownout_mode_field == 2'h1) | (brownout_mode_field == 2'h3) |
                     ((brownout_mode_field == 2'h2) & ~sleep_active);
  wire bor_event   = bor_enabled & (bor_cnt == `RTSEQ_BOR_CYCLES);
  wire pin_reset   = ext_reset_pin_enable & pin_low_filt;
  wire wdr_event   = sync_wdr[1] & ~wdr_prev;
  wire wdw_event   = sync_wdw[1] & ~wdw_prev;
  wire pin_event   = pin_reset & ~pin_prev;
  wire is_crystal  = (clock_mode == 2'h1);
  wire osc_tick    = (osc_div_cnt == OSC_DIV - 16'h0001);
  wire powerup_timer_on     = ~powerup_timer_disable;
  // A disabled pin reads as released, so re-enabling it cannot replay an old low level.
  wire pin_seen    = sync_pin[1] | ~ext_reset_pin_enable;

  // Weak pull-up and pin drive: watchdog never pulls the pin low.
  assign pin_pullup_en = ext_reset_pin_enable;
  assign pin_out       = 1'b0;
  assign pin_oe        = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for the external levels.
  always @(posedge clock) begin
    if (reset) begin
      sync_por <= 2'h0;
      sync_bor <= 2'h0;
      sync_pin <= 2'h3;
      sync_wdr <= 2'h0;
      sync_wdw <= 2'h0;
    end else begin
      sync_por <= {sync_por[0], supply_ok_por};
      sync_bor <= {sync_bor[0], supply_above_bor};
      sync_pin <= {sync_pin[0], pin_level_in};
      sync_wdr <= {sync_wdr[0], watchdog_reset};
      sync_wdw <= {sync_wdw[0], watchdog_wake};
    end
  end

  // Glitch filter on the pin and minimum-duration filter on brown-out.
  always @(posedge clock) begin
    if (reset) begin
      filt_cnt     <= 4'h0;
      pin_low_filt <= 1'b0;
      bor_cnt      <= 5'h00;
      wdr_prev     <= 1'b0;
      wdw_prev     <= 1'b0;
      pin_prev     <= 1'b0;
    end else begin
      wdr_prev <= sync_wdr[1];
      wdw_prev <= sync_wdw[1];
      pin_prev <= pin_reset;
      if (pin_seen == pin_low_filt) begin
        if (filt_cnt == `RTSEQ_FILT_CYCLES - 1) begin
          filt_cnt     <= 4'h0;
          pin_low_filt <= ~pin_seen;
        end else begin
          filt_cnt <= filt_cnt + 4'h1;
        end
      end else begin
        filt_cnt <= 4'h0;
      end
      if (sync_bor[1] | ~bor_enabled) begin
        bor_cnt <= 5'h00;
      end else if (bor_cnt != `RTSEQ_BOR_CYCLES) begin
        bor_cnt <= bor_cnt + 5'h01;
      end
    end
  end

  // Oscillator period divider for the crystal start-up count.
  always @(posedge clock) begin
    if (reset | osc_tick) begin
      osc_div_cnt <= 16'h0000;
    end else begin
      osc_div_cnt <= osc_div_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence: power-on, brown-out wait, power-up timer, crystal timer, run.
  always @(posedge clock) begin
    if (reset) begin
      state    <= ST_POR;
      powerup_timer_cnt <= 32'h0;
      ost_cnt  <= 11'h000;
    end else if (por_low) begin
      state    <= ST_POR;
      powerup_timer_cnt <= 32'h0;
    end else if (bor_event) begin
      state    <= ST_BOR;
      powerup_timer_cnt <= 32'h0;
    end else begin
      case (state)
        ST_POR, ST_BOR: begin
          powerup_timer_cnt <= 32'h0;
          ost_cnt  <= 11'h000;
          if (sync_bor[1] | ~bor_enabled) begin
            if (powerup_timer_on) begin
              state <= ST_POWERUP_TIMER;
            end else if (is_crystal) begin
              state <= ST_OST;
            end else begin
              state <= ST_HOLD;
            end
          end
        end
        ST_POWERUP_TIMER: begin
          if (~sync_bor[1] & bor_enabled) begin
            powerup_timer_cnt <= 32'h0;
          end else if (powerup_timer_cnt == POWERUP_TIMER_CYCLES - 1) begin
            state   <= is_crystal ? ST_OST : ST_HOLD;
            ost_cnt <= 11'h000;
          end else begin
            powerup_timer_cnt <= powerup_timer_cnt + 32'h1;
          end
        end
        ST_OST, ST_WAKE: begin
          if (ost_cnt == `RTSEQ_OST_PERIODS) begin
            state <= ST_HOLD;
          end else if (osc_tick) begin
            ost_cnt <= ost_cnt + 11'h001;
          end
        end
        ST_HOLD: begin
          if (~pin_reset) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (pin_reset | wdr_event) begin
            state <= ST_HOLD;
          end else if (wdw_event & is_crystal) begin
            state   <= ST_WAKE;
            ost_cnt <= 11'h000;
          end
        end
        default: state <= ST_POR;
      endcase
    end
  end

  // Core reset leaves on a clock edge once everything is quiet.
  always @(posedge clock) begin
    if (reset) begin
      core_reset <= 1'b1;
    end else begin
      core_reset <= ~((state == ST_RUN) | (state == ST_WAKE)) | por_low | pin_reset |
                    (state == ST_WAKE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cause flags and APB writes; hardware events win over software writes.
  wire apb_wr = psel & penable & pwrite;

  always @(posedge clock) begin
    if (reset) begin
      por_flag     <= 1'b0;
      bor_flag     <= 1'b0;
      to_flag      <= 1'b1;
      pd_flag      <= 1'b1;
      status_upper <= 3'h0;
      clock_mode   <= 2'h0;
    end else begin
      if (apb_wr & (paddr == `RTSEQ_ADDR_POWER_CONTROL_REG)) begin
        if (pwdata[`RTSEQ_POWER_CONTROL_REG_POR_BIT]) por_flag <= 1'b1;
        if (pwdata[`RTSEQ_POWER_CONTROL_REG_BOR_BIT]) bor_flag <= 1'b1;
      end
      if (apb_wr & (paddr == `RTSEQ_ADDR_STATUS)) begin
        status_upper <= pwdata[7:5];
      end
      if (apb_wr & (paddr == `RTSEQ_ADDR_CONFIG)) begin
        clock_mode <= pwdata[1:0];
      end
      if (por_low) begin
        por_flag     <= 1'b0;
        to_flag      <= 1'b1;
        pd_flag      <= 1'b1;
        status_upper <= 3'h0;
      end else if (bor_event) begin
        bor_flag     <= 1'b0;
        to_flag      <= 1'b1;
        pd_flag      <= 1'b1;
        status_upper <= 3'h0;
      end else if (wdw_event & sleep_active) begin
        to_flag <= 1'b0;
        pd_flag <= 1'b0;
      end else if (wdr_event) begin
        to_flag      <= 1'b0;
        status_upper <= 3'h0;
      end else if (pin_event) begin
        status_upper <= 3'h0;
        if (sleep_active) begin
          to_flag <= 1'b1;
          pd_flag <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read decode; zero-wait answers, unmapped addresses read zero with error.
  always @* begin
    case (paddr)
      `RTSEQ_ADDR_POWER_CONTROL_REG:   rdata = {30'h0, por_flag, bor_flag};
      `RTSEQ_ADDR_STATUS: rdata = {24'h0, status_upper, to_flag, pd_flag, 3'h0};
      `RTSEQ_ADDR_CONFIG: rdata = {30'h0, clock_mode};
      `RTSEQ_ADDR_STATE:  rdata = {24'h0, powerup_timer_on, brownout_mode_field, ext_reset_pin_enable,
                                   core_reset, state};
      default:            rdata = 32'h0;
    endcase
  end

  assign prdata  = rdata;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (paddr != `RTSEQ_ADDR_POWER_CONTROL_REG) &
                   (paddr != `RTSEQ_ADDR_STATUS) & (paddr != `RTSEQ_ADDR_CONFIG) &
                   (paddr != `RTSEQ_ADDR_STATE);

endmodule // rtseq_top

`default_nettype wire

// ### rtseq_consts.vh
// Constants for the reset and time-out sequencer.
`ifndef RTSEQ_CONSTS_VH
`define RTSEQ_CONSTS_VH
`define RTSEQ_IDX_POWER_CONTROL_REG       12'h08E
`define RTSEQ_ADDR_POWER_CONTROL_REG      12'h238
`define RTSEQ_ADDR_STATUS    12'h090
`define RTSEQ_ADDR_CONFIG    12'h094
`define RTSEQ_ADDR_STATE     12'h098
`define RTSEQ_POWER_CONTROL_REG_BOR_BIT   0
`define RTSEQ_POWER_CONTROL_REG_POR_BIT   1
`define RTSEQ_ST_PD_BIT      3
`define RTSEQ_ST_TO_BIT      4
`define RTSEQ_STATUS_RESET   8'h18
`define RTSEQ_CONFIG_RESET   8'h10
`define RTSEQ_POWERUP_TIMER_MS        64
`define RTSEQ_CLK_MHZ        125
`define RTSEQ_POWERUP_TIMER_CYCLES    (`RTSEQ_POWERUP_TIMER_MS * 1000 * `RTSEQ_CLK_MHZ)
`define RTSEQ_OST_PERIODS    1024
`define RTSEQ_FILT_CYCLES    8
`define RTSEQ_BOR_CYCLES     16
`endif

// ### rtseq_assertions.sv
// Port-level checks of the reset sequencer.
`timescale 1ns/1ps
`default_nettype none
module rtseq_checks #(
  parameter [31:0] POWERUP_TIMER_CYCLES = 32'h0000_0032
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        supply_ok_por,
  input wire logic        supply_above_bor,
  input wire logic        pin_level_in,
  input wire logic        pin_pullup_en,
  input wire logic        pin_out,
  input wire logic        pin_oe,
  input wire logic        watchdog_reset,
  input wire logic        ext_reset_pin_enable,
  input wire logic        powerup_timer_disable,
  input wire logic        core_reset
);
  logic [31:0] ok_cnt;
  // Counts cycles of healthy supply, so a release can be held against the timer.
  always_ff @(posedge clock) begin
    if (reset || !supply_ok_por || !supply_above_bor)
      ok_cnt <= 32'h0;
    else if (ok_cnt != 32'hFFFF_FFFF)
      ok_cnt <= ok_cnt + 32'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_por_holds: assert property (!supply_ok_por [*4] |-> core_reset)
    else $error("core ran while supply low");
  a_glitch_ignored: assert property ((!core_reset && pin_level_in) ##1 !pin_level_in [*2]
    ##1 pin_level_in |-> !core_reset [*8]) else $error("glitch caused reset");
  a_pin_undriven: assert property (!pin_oe && !pin_out)
    else $error("reset pin driven");
  a_pin_disabled: assert property ((!core_reset && !ext_reset_pin_enable
    && !pin_level_in && !watchdog_reset) [*8] |=> !core_reset) else $error("pin not ignored");
  a_pullup_follows: assert property (pin_pullup_en == ext_reset_pin_enable)
    else $error("pull-up wrong");
  a_timer_held: assert property ($fell(core_reset) && !powerup_timer_disable
    |-> ok_cnt >= POWERUP_TIMER_CYCLES) else $error("released before power-up timer");
  a_release_clean: assert property ($fell(core_reset) |-> ok_cnt > 32'h1
    && (!ext_reset_pin_enable || $past(pin_level_in))) else $error("release with source active");
  a_unmapped_err: assert property (psel && penable && paddr == 12'h0FC
    |-> pslverr && prdata == 32'h0) else $error("unmapped access accepted");
  a_mapped_ok: assert property (psel && penable && paddr == 12'h090 |-> !pslverr)
    else $error("mapped access refused");
endmodule // rtseq_checks
bind rtseq_top rtseq_checks #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER_CYCLES)) u_checks (.*);
`default_nettype wire

// ### rtseq_far_side.sv
// Model of the supply monitors and the external reset pin.
`timescale 1ns/1ps
`default_nettype none
module rtseq_far_side (
  input  wire logic       clock,
  input  wire logic [1:0] vdd_level,
  input  wire logic       pin_held_low,
  input  wire logic       pin_pullup_en,
  output logic            supply_ok_por,
  output logic            supply_above_bor,
  output logic            pin_level_in
);
  logic drift = 1'b0;
  always @(posedge clock) drift <= !drift;
  // Level 0 is below the power-on point, 1 between thresholds, 2 healthy.
  assign supply_ok_por = vdd_level != 2'h0;
  assign supply_above_bor = vdd_level == 2'h2;
  // Without the pull-up a released pin floats and wanders.
  assign pin_level_in = pin_held_low ? 1'b0 : (pin_pullup_en | drift);
endmodule // rtseq_far_side
`default_nettype wire

// ### rtseq_top_test.sv
// Self-checking bench for the reset sequencer.
`timescale 1ns/1ps
`default_nettype none
module rtseq_top_test;
  localparam int P = 50;
  logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, pin_out, pin_oe, pin_pullup_en, core_reset, err;
  logic supply_ok_por, supply_above_bor, pin_level_in, pin_held_low = 0;
  logic watchdog_reset = 0, sleep_active = 0, ext_reset_pin_enable = 1;
  logic watchdog_wake = 0;
  logic powerup_timer_disable = 0;
  logic [1:0] brownout_mode_field = 2'h1, vdd_level = 2'h2;
  int fails = 0, checks = 0, n;
  rtseq_top #(.POWERUP_TIMER_CYCLES(P), .OSC_DIV(16'h0001)) dut (.*);
  rtseq_far_side far (.*);
  always #4 clock = ~clock;
  task cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task core_is(input logic e);
    check({31'h0, core_reset}, {31'h0, e});
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    n = 0;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    if (pready !== 1'b1) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    check(rd, e);
  endtask
  task dip(input int k);
    vdd_level <= 2'h1;
    cyc(k);
    vdd_level <= 2'h2;
  endtask
  task rel(input int lo, input int hi);
    n = 0;
    while (core_reset !== 1'b0 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    check({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask
  task results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    results;
  end
  initial begin
    cyc(2);
    reset <= 0;
    rel(P, P + 12);
    rdchk(12'h238, 32'h0);
    rdchk(12'h090, 32'h18);
    apb(1, 12'h238, 32'h3);
    rdchk(12'h238, 32'h3);
    dip(30);
    core_is(1);
    cyc(20);
    dip(30);
    rel(P, P + 12);
    rdchk(12'h238, 32'h2);
    pin_held_low <= 1;
    cyc(2);
    pin_held_low <= 0;
    cyc(12);
    core_is(0);
    pin_held_low <= 1;
    cyc(20);
    core_is(1);
    pin_held_low <= 0;
    rel(1, 14);
    rdchk(12'h090, 32'h18);
    ext_reset_pin_enable <= 0;
    pin_held_low <= 1;
    cyc(20);
    core_is(0);
    pin_held_low <= 0;
    ext_reset_pin_enable <= 1;
    cyc(12);
    watchdog_reset <= 1;
    n = 0;
    repeat (12) begin
      @(posedge clock);
      n += int'(core_reset === 1'b1);
    end
    watchdog_reset <= 0;
    check({31'h0, n > 0 && n < 8}, 32'h1);
    rdchk(12'h090, 32'h08);
    apb(1, 12'h094, 32'h1);
    dip(30);
    rel(P + 1024, P + 1040);
    sleep_active <= 1;
    watchdog_wake <= 1;
    cyc(6);
    watchdog_wake <= 0;
    sleep_active <= 0;
    core_is(1);
    rel(1000, 1040);
    rdchk(12'h090, 32'h00);
    powerup_timer_disable <= 1;
    dip(30);
    rel(1024, 1040);
    apb(1, 12'h094, 32'h0);
    dip(30);
    rel(0, 8);
    powerup_timer_disable <= 0;
    brownout_mode_field <= 2'h2;
    sleep_active <= 1;
    dip(30);
    core_is(0);
    sleep_active <= 0;
    dip(30);
    core_is(1);
    rel(P, P + 12);
    apb(1, 12'h0FC, 32'hFF);
    rdchk(12'h0FC, 32'h0);
    check({31'h0, err}, 32'h1);
    vdd_level <= 2'h0;
    cyc(10);
    core_is(1);
    vdd_level <= 2'h2;
    rel(P, P + 12);
    apb(0, 12'h238, 32'h0);
    check(rd & 32'h2, 32'h0);
    rdchk(12'h090, 32'h18);
    results;
  end
endmodule // rtseq_top_test
`default_nettype wire
